/* File: src/card_if_pkg.sv */
// constants and carrier types of the card interface status block
package card_if_pkg;
  // register byte offsets
  localparam logic [7:0] CMD_OFS     = 8'h00;
  localparam logic [7:0] MODE_OFS    = 8'h04;
  localparam logic [7:0] DTO_OFS     = 8'h08;
  localparam logic [7:0] RXDATA_OFS  = 8'h0C;
  localparam logic [7:0] TXDATA_OFS  = 8'h10;
  localparam logic [7:0] STATUS_OFS  = 8'h14;
  localparam logic [7:0] IRQ_SET_OFS = 8'h18;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h1C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
  // command word fields
  localparam int CMD_INDEX_LSB = 0;
  localparam int CMD_INDEX_W   = 6;
  localparam int RSP_TYPE_LSB  = 6;
  localparam int MAX_RESPONSE_LATENCY_BIT    = 12;
  localparam int TRCMD_LSB     = 16;
  localparam logic [1:0] TRCMD_START = 2'h1;
  // mode and timeout fields
  localparam int DMA_MODE_BIT  = 15;
  localparam int DTO_CYC_LSB   = 0;
  localparam int DTO_MUL_LSB   = 4;
  // status bit positions, shared by mask registers
  localparam int B_CMD_READY   = 0;
  localparam int B_RX_READY    = 1;
  localparam int B_TX_READY    = 2;
  localparam int B_BLOCK_END   = 3;
  localparam int B_XFER_BUSY   = 4;
  localparam int B_CARD_READY  = 5;
  localparam int B_RX_END      = 6;
  localparam int B_TX_END      = 7;
  localparam int B_RX_FULL     = 14;
  localparam int B_TX_EMPTY    = 15;
  localparam int B_RESP_INDEX  = 16;
  localparam int B_RESP_DIR    = 17;
  localparam int B_RESP_CRC    = 18;
  localparam int B_RESP_END    = 19;
  localparam int B_RESP_TIME   = 20;
  localparam int B_DATA_CRC    = 21;
  localparam int B_DATA_TIME   = 22;
  localparam int B_OVERRUN     = 30;
  localparam int B_UNDERRUN    = 31;
  localparam logic [31:0] STATUS_USED = 32'hC07F_C0FF;
  // timing counts
  localparam int RESP_LAT_SHORT = 5;
  localparam int RESP_LAT_LONG  = 64;
  localparam int MUL_0 = 1;
  localparam int MUL_1 = 16;
  localparam int MUL_2 = 128;
  localparam int MUL_3 = 256;
  localparam int MUL_4 = 1024;
  localparam int MUL_5 = 4096;
  localparam int TIMER_W = 24;

  typedef struct packed {
    logic [5:0] index;
    logic       dir_bit;
    logic       end_bit;
    logic [6:0] crc_recv;
    logic [6:0] crc_calc;
  } resp_report_t;

  typedef struct packed {
    logic [15:0] crc_recv;
    logic [15:0] crc_calc;
  } data_crc_t;
endpackage

/* File: src/card_if_status_irq.sv */
// status, interrupt mask and data registers of the card interface
//
// Overview of operation
// - command ready low while command runs, set when sent, cleared by command write
// - receive ready set on new data, cleared by reading receive data
// - transmit ready set when written word enters shifter, clear while waiting
// - block ended at last block in DMA mode, else first; status read clears
// - transfer busy held until trailing checksum finishes
// - card ready follows data line 0 high
// - receive end set when counter reaches zero, cleared by counter writes
// - transmit end set when counter reaches zero, cleared by counter writes
// - buffer full/empty exactly when both counters are zero
// - response index mismatch sets error, command write clears
// - missing direction bit in response sets error
// - response 7-bit checksum mismatch sets error, command write clears
// - missing response end bit sets error, command write clears
// - no response start within latency sets timeout, command write clears
// - data 16-bit checksum mismatch sets error, new transfer command clears
// - inter-block wait over programmed limit sets timeout, command write clears
// - lost received data sets overrun, new transfer command clears
// - sending unwritten data sets underrun, new transfer command clears
// - enable write sets mask bits written as one, only at used status positions
// - disable write clears mask bits written as one
// - mask view reads back enabled positions
// - response latency 5 or 64 card cycles by command bit
// - data timeout is cycle count times coded multiplier
// - overrun and underrun inactive in DMA mode
// - command writes ignored while command ready is low
`timescale 1ns/1ps
module card_if_status_irq #(
  parameter int MUL_6 = 65536,
  parameter int MUL_7 = 1048576
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      card_data_line0,
  input  wire logic                      card_clk_tick,
  input  wire logic                      cmd_sent,
  input  wire logic                      resp_start,
  input  wire logic                      resp_valid,
  input  wire card_if_pkg::resp_report_t resp,
  input  wire logic                      rx_word_valid,
  input  wire logic [31:0]               rx_word,
  input  wire logic                      tx_shift_load,
  input  wire logic                      block_end,
  input  wire logic                      last_block,
  input  wire logic                      data_wait,
  input  wire logic                      data_crc_valid,
  input  wire card_if_pkg::data_crc_t    data_crc,
  input  wire logic                      xfer_crc_done,
  input  wire logic                      rx_counter_zero,
  input  wire logic                      rx_next_counter_zero,
  input  wire logic                      tx_counter_zero,
  input  wire logic                      tx_next_counter_zero,
  input  wire logic                      rx_counter_write,
  input  wire logic                      tx_counter_write,
  output logic      [31:0]               cmd_word,
  output logic                           cmd_start,
  output logic      [31:0]               tx_data,
  output logic                           dma_oriented_mode,
  output logic                           irq
);
  if (MUL_6 < 1 || MUL_7 < MUL_6 || MUL_7 > 1048576)
  begin : bad_multiplier
    $error("timeout multipliers out of range");
  end

  localparam int TW = card_if_pkg::TIMER_W;

  logic        setup;
  logic        wr;
  logic        rd;
  logic        cmd_wr;
  logic        data_cmd;
  logic        status_rd;
  logic        rxdata_rd;
  logic [31:0] status;
  logic [31:0] mask;
  logic [31:0] rx_data;
  logic [31:0] next_rdata;
  logic        next_err;
  logic [3:0]  dto_cyc;
  logic [2:0]  dto_mul;
  logic [TW-1:0] dto_limit;
  logic [TW-1:0] resp_limit;
  logic        cmd_ready;
  logic        rx_ready;
  logic        tx_ready;
  logic        block_ended;
  logic        first_seen;
  logic        xfer_busy;
  logic [2:0]  card_data_line0_sync;
  logic        card_ready;
  logic        rx_end;
  logic        tx_end;
  logic        rx_full;
  logic        tx_empty;
  logic [6:0]  resp_err;
  logic        overrun;
  logic        underrun;
  logic        resp_wait;
  logic        resp_timeout;
  logic        data_timeout;
  logic        rx_hit_d;

  ////////////////////////////////////////////////////////////////////////
  // apb slave

  assign setup     = psel && !penable;
  assign wr        = psel && penable && pready && pwrite;
  assign rd        = psel && penable && pready && !pwrite;
  assign cmd_wr    = wr && paddr == card_if_pkg::CMD_OFS && cmd_ready;
  assign data_cmd  = cmd_wr && pwdata[card_if_pkg::TRCMD_LSB +: 2] == card_if_pkg::TRCMD_START;
  assign status_rd = rd && paddr == card_if_pkg::STATUS_OFS;
  assign rxdata_rd = rd && paddr == card_if_pkg::RXDATA_OFS;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    unique case (paddr)
      card_if_pkg::MODE_OFS:     next_rdata[card_if_pkg::DMA_MODE_BIT] = dma_oriented_mode;
      card_if_pkg::DTO_OFS:      next_rdata[6:0] = {dto_mul, dto_cyc};
      card_if_pkg::RXDATA_OFS:   next_rdata = rx_data;
      card_if_pkg::STATUS_OFS:   next_rdata = status;
      card_if_pkg::IRQ_MASK_OFS: next_rdata = mask;
      card_if_pkg::CMD_OFS, card_if_pkg::TXDATA_OFS,
      card_if_pkg::IRQ_SET_OFS, card_if_pkg::IRQ_CLR_OFS: next_rdata = 32'h0000_0000;
      default:                   next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      prdata  <= setup ? next_rdata : 32'h0000_0000;
      pslverr <= setup && next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_oriented_mode <= 1'b0;
      dto_cyc           <= 4'h0;
      dto_mul           <= 3'h0;
    end
    else if (wr && paddr == card_if_pkg::MODE_OFS)
      dma_oriented_mode <= pwdata[card_if_pkg::DMA_MODE_BIT];
    else if (wr && paddr == card_if_pkg::DTO_OFS)
    begin
      dto_cyc <= pwdata[card_if_pkg::DTO_CYC_LSB +: 4];
      dto_mul <= pwdata[card_if_pkg::DTO_MUL_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_word  <= 32'h0000_0000;
      cmd_start <= 1'b0;
    end
    else
    begin
      cmd_start <= cmd_wr;
      if (cmd_wr)
        cmd_word <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_data <= 32'h0000_0000;
    else if (wr && paddr == card_if_pkg::TXDATA_OFS)
      tx_data <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask <= 32'h0000_0000;
    else if (wr && paddr == card_if_pkg::IRQ_SET_OFS)
      mask <= mask | (pwdata & card_if_pkg::STATUS_USED);
    else if (wr && paddr == card_if_pkg::IRQ_CLR_OFS)
      mask <= mask & ~pwdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // command, data and buffer flags

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_ready <= 1'b1;
    else if (cmd_sent)
      cmd_ready <= 1'b1;
    else if (cmd_wr)
      cmd_ready <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_ready <= 1'b0;
      rx_data  <= 32'h0000_0000;
      rx_hit_d <= 1'b0;
    end
    else
    begin
      rx_hit_d <= rx_word_valid;
      if (rx_word_valid)
      begin
        rx_ready <= 1'b1;
        rx_data  <= rx_word;
      end
      else if (rxdata_rd && !rx_hit_d)
        rx_ready <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_ready <= 1'b1;
    else if (tx_shift_load)
      tx_ready <= 1'b1;
    else if (wr && paddr == card_if_pkg::TXDATA_OFS)
      tx_ready <= 1'b0;
  end

  // a flag is only cleared by a status read that reported it set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      block_ended <= 1'b0;
      first_seen  <= 1'b0;
    end
    else
    begin
      if (data_cmd)
        first_seen <= 1'b0;
      else if (block_end)
        first_seen <= 1'b1;
      if (block_end && (dma_oriented_mode ? last_block : !first_seen))
        block_ended <= 1'b1;
      else if (status_rd && prdata[card_if_pkg::B_BLOCK_END])
        block_ended <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      xfer_busy <= 1'b0;
    else if (data_cmd)
      xfer_busy <= 1'b1;
    else if (xfer_crc_done)
      xfer_busy <= 1'b0;
  end

  // three-stage pin sampler, change taken when last two agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_data_line0_sync  <= 3'h0;
      card_ready <= 1'b0;
    end
    else
    begin
      card_data_line0_sync <= {card_data_line0_sync[1:0], card_data_line0};
      if (card_data_line0_sync[1] == card_data_line0_sync[2])
        card_ready <= card_data_line0_sync[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_end   <= 1'b0;
      tx_end   <= 1'b0;
      rx_full  <= 1'b0;
      tx_empty <= 1'b0;
    end
    else
    begin
      if (rx_counter_write)
        rx_end <= 1'b0;
      else if (rx_counter_zero)
        rx_end <= 1'b1;
      if (tx_counter_write)
        tx_end <= 1'b0;
      else if (tx_counter_zero)
        tx_end <= 1'b1;
      rx_full  <= rx_counter_zero && rx_next_counter_zero;
      tx_empty <= tx_counter_zero && tx_next_counter_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // response and data errors

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      resp_wait <= 1'b0;
    else if (cmd_wr)
      resp_wait <= pwdata[card_if_pkg::RSP_TYPE_LSB +: 2] != 2'h0;
    else if (resp_start || resp_timeout)
      resp_wait <= 1'b0;
  end

  assign resp_limit = cmd_word[card_if_pkg::MAX_RESPONSE_LATENCY_BIT] ? TW'(card_if_pkg::RESP_LAT_LONG)
                                                        : TW'(card_if_pkg::RESP_LAT_SHORT);

  timeout_counter #(
    .W (TW)
  ) resp_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (resp_wait && !cmd_start),
    .tick    (card_clk_tick),
    .limit   (resp_limit),
    .expired (resp_timeout)
  );

  always_comb
  begin
    unique case (dto_mul)
      3'h0: dto_limit = TW'(card_if_pkg::MUL_0);
      3'h1: dto_limit = TW'(card_if_pkg::MUL_1);
      3'h2: dto_limit = TW'(card_if_pkg::MUL_2);
      3'h3: dto_limit = TW'(card_if_pkg::MUL_3);
      3'h4: dto_limit = TW'(card_if_pkg::MUL_4);
      3'h5: dto_limit = TW'(card_if_pkg::MUL_5);
      3'h6: dto_limit = TW'(MUL_6);
      3'h7: dto_limit = TW'(MUL_7);
    endcase
    dto_limit = TW'(dto_limit * TW'(dto_cyc));
  end

  timeout_counter #(
    .W (TW)
  ) data_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (data_wait && xfer_busy),
    .tick    (1'b1),
    .limit   (dto_limit),
    .expired (data_timeout)
  );

  // bits: index, dir, crc, end, resp timeout, data crc, data timeout
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      resp_err <= 7'h00;
    else
    begin
      if (resp_valid && resp.index != cmd_word[card_if_pkg::CMD_INDEX_LSB +: card_if_pkg::CMD_INDEX_W])
        resp_err[0] <= 1'b1;
      else if (cmd_wr)
        resp_err[0] <= 1'b0;
      if (resp_valid && !resp.dir_bit)
        resp_err[1] <= 1'b1;
      else if (cmd_wr)
        resp_err[1] <= 1'b0;
      if (resp_valid && resp.crc_recv != resp.crc_calc)
        resp_err[2] <= 1'b1;
      else if (cmd_wr)
        resp_err[2] <= 1'b0;
      if (resp_valid && !resp.end_bit)
        resp_err[3] <= 1'b1;
      else if (cmd_wr)
        resp_err[3] <= 1'b0;
      if (resp_timeout)
        resp_err[4] <= 1'b1;
      else if (cmd_wr)
        resp_err[4] <= 1'b0;
      if (data_crc_valid && data_crc.crc_recv != data_crc.crc_calc)
        resp_err[5] <= 1'b1;
      else if (data_cmd)
        resp_err[5] <= 1'b0;
      if (data_timeout)
        resp_err[6] <= 1'b1;
      else if (cmd_wr)
        resp_err[6] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overrun  <= 1'b0;
      underrun <= 1'b0;
    end
    else
    begin
      if (rx_word_valid && rx_ready && !(rxdata_rd && !rx_hit_d) && !dma_oriented_mode)
        overrun <= 1'b1;
      else if (data_cmd)
        overrun <= 1'b0;
      if (tx_shift_load && tx_ready && !dma_oriented_mode)
        underrun <= 1'b1;
      else if (data_cmd)
        underrun <= 1'b0;
    end
  end

  always_comb
  begin
    status = 32'h0000_0000;
    status[card_if_pkg::B_CMD_READY]  = cmd_ready;
    status[card_if_pkg::B_RX_READY]   = rx_ready;
    status[card_if_pkg::B_TX_READY]   = tx_ready;
    status[card_if_pkg::B_BLOCK_END]  = block_ended;
    status[card_if_pkg::B_XFER_BUSY]  = xfer_busy;
    status[card_if_pkg::B_CARD_READY] = card_ready;
    status[card_if_pkg::B_RX_END]     = rx_end;
    status[card_if_pkg::B_TX_END]     = tx_end;
    status[card_if_pkg::B_RX_FULL]    = rx_full;
    status[card_if_pkg::B_TX_EMPTY]   = tx_empty;
    status[card_if_pkg::B_DATA_TIME:card_if_pkg::B_RESP_INDEX] = resp_err;
    status[card_if_pkg::B_OVERRUN]    = overrun;
    status[card_if_pkg::B_UNDERRUN]   = underrun;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence reported_block_s;
    status_rd && prdata[card_if_pkg::B_BLOCK_END];
  endsequence

  sequence locked_cmd_s;
    wr && paddr == card_if_pkg::CMD_OFS && !cmd_ready;
  endsequence

  cmd_locked_a: assert property (locked_cmd_s |=> $stable(cmd_word) && !cmd_start)
    else $error("command written while busy");
  cmd_clear_a: assert property (cmd_wr && !cmd_sent |=> !cmd_ready ##0 cmd_start)
    else $error("command ready not cleared");
  rx_set_a: assert property (rx_word_valid |=> rx_ready && rx_data == $past(rx_word))
    else $error("receive ready not set");
  tx_wait_a: assert property (wr && paddr == card_if_pkg::TXDATA_OFS && !tx_shift_load |=> !tx_ready)
    else $error("transmit ready not cleared");
  block_clear_a: assert property (reported_block_s ##0 !block_end |=> !block_ended)
    else $error("block ended not cleared");
  dma_quiet_a: assert property ($rose(overrun) || $rose(underrun) |-> !$past(dma_oriented_mode))
    else $error("overrun flag in dma mode");
  buf_full_a: assert property (rx_counter_zero && rx_next_counter_zero |=> rx_full)
    else $error("buffer full missing");
  mask_set_a: assert property (wr && paddr == card_if_pkg::IRQ_SET_OFS |=>
    (mask & $past(pwdata) & card_if_pkg::STATUS_USED) == ($past(pwdata) & card_if_pkg::STATUS_USED))
    else $error("mask bit not set");
  mask_clr_a: assert property (wr && paddr == card_if_pkg::IRQ_CLR_OFS |=> (mask & $past(pwdata)) == 0)
    else $error("mask bit not cleared");
  irq_level_a: assert property (##1 irq == |($past(status) & $past(mask)))
    else $error("interrupt level wrong");
  resp_crc_a: assert property (resp_valid && resp.crc_recv != resp.crc_calc |=> status[card_if_pkg::B_RESP_CRC])
    else $error("response checksum error missed");
  card_ready_a: assert property (card_data_line0_sync[2] && card_data_line0_sync[1] |=> card_ready)
    else $error("card ready not following line");
endmodule

/* File: src/timeout_counter.sv */
// tick counter that pulses once when the wait passes its limit
`timescale 1ns/1ps
module timeout_counter #(
  parameter int W = 24
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              expired
);
  logic [W-1:0] count;
  logic         fired;
  logic [W-1:0] next_count;

  assign next_count = count + W'(1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count   <= '0;
      fired   <= 1'b0;
      expired <= 1'b0;
    end
    else if (!run)
    begin
      count   <= '0;
      fired   <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (tick && !fired)
      begin
        count <= next_count;
        if (next_count > limit)
        begin
          expired <= 1'b1;
          fired   <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: verif/card_model.sv */
// card side model: data line 0 level for free or busy card
`timescale 1ns/1ps
module card_model (
  input  wire logic pclk,
  input  wire logic busy,
  output logic      card_data_line0
);
  initial card_data_line0 = 1'b1;
  // low while busy, high when the receive buffer is free
  always @(posedge pclk)
  begin
    card_data_line0 <= ~busy;
  end
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the card interface status block
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, busy = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, cmd_word, tx_data, rx_word = 0, q;
  logic pready, pslverr, cmd_start, dma_oriented_mode, irq, card_data_line0, slv;
  logic card_clk_tick = 0, last_block = 0, data_wait = 0;
  logic rx_counter_zero = 0, rx_next_counter_zero = 0, tx_counter_zero = 0, tx_next_counter_zero = 0;
  // event strobes, one bit per pulse input
  logic [9:0] ev = '0;
  localparam int CSENT = 0, RSTART = 1, RVALID = 2, RXV = 3, TXL = 4;
  localparam int BEND = 5, CRCD = 6, RXCW = 7, DCRC = 8, TXCW = 9;
  logic [2:0] tick_cnt = 0;
  card_if_pkg::resp_report_t resp = '0;
  card_if_pkg::data_crc_t data_crc = '0;
  int err_count = 0, total_checks = 0;

  card_if_status_irq #(.MUL_6(32), .MUL_7(64)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .card_data_line0, .card_clk_tick, .cmd_sent(ev[CSENT]),
    .resp_start(ev[RSTART]), .resp_valid(ev[RVALID]), .resp, .rx_word_valid(ev[RXV]), .rx_word,
    .tx_shift_load(ev[TXL]), .block_end(ev[BEND]), .last_block, .data_wait, .data_crc_valid(ev[DCRC]),
    .data_crc, .xfer_crc_done(ev[CRCD]), .rx_counter_zero, .rx_next_counter_zero, .tx_counter_zero,
    .tx_next_counter_zero, .rx_counter_write(ev[RXCW]), .tx_counter_write(ev[TXCW]), .cmd_word,
    .cmd_start, .tx_data, .dma_oriented_mode, .irq);
  card_model card (.pclk(pclk), .busy(busy), .card_data_line0(card_data_line0));

  always #25 pclk = ~pclk;
  // card clock tick every 400 ns
  always @(posedge pclk)
  begin
    tick_cnt <= tick_cnt + 3'h1;
    card_clk_tick <= (tick_cnt == 3'h6);
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      wrap_up();
    end
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, card_if_pkg::STATUS_OFS, 32'h0);
    chk(q & m, e);
  endtask

  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_reset();
    // let the pin sampler settle before the first status read
    repeat (4) @(posedge pclk);
    stat(32'hFFFF_FFFF, 32'h0000_0025);
    apb(1'b0, card_if_pkg::IRQ_MASK_OFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, slv}, 32'h1);
    busy <= 1'b1;
    repeat (6) @(posedge pclk);
    stat(32'h0000_0020, 32'h0);
    busy <= 1'b0;
    $display("reset test done");
  endtask

  task automatic t_irq();
    apb(1'b1, card_if_pkg::IRQ_SET_OFS, 32'hC07F_C0FF);
    apb(1'b0, card_if_pkg::IRQ_MASK_OFS, 32'h0);
    chk(q, 32'hC07F_C0FF);
    apb(1'b1, card_if_pkg::IRQ_CLR_OFS, 32'h807F_C0FD);
    apb(1'b0, card_if_pkg::IRQ_MASK_OFS, 32'h0);
    chk(q, 32'h4000_0002);
    rx_word <= 32'hA5A5_5A5A;
    pulse(RXV);
    chk({31'h0, irq}, 32'h1);
    stat(32'h0000_0002, 32'h2);
    pulse(RXV);
    stat(32'h4000_0000, 32'h4000_0000);
    apb(1'b0, card_if_pkg::RXDATA_OFS, 32'h0);
    chk(q, 32'hA5A5_5A5A);
    stat(32'h0000_0002, 32'h0);
    apb(1'b1, card_if_pkg::IRQ_CLR_OFS, 32'h4000_0000);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("irq test done");
  endtask

  task automatic t_cmd();
    apb(1'b1, card_if_pkg::CMD_OFS, 32'h0000_0045);
    stat(32'h0000_0001, 32'h0);
    apb(1'b1, card_if_pkg::CMD_OFS, 32'h0000_0046);
    chk(cmd_word, 32'h0000_0045);
    repeat (80) @(posedge pclk);
    stat(32'h0010_0000, 32'h0010_0000);
    pulse(CSENT);
    stat(32'h0010_0001, 32'h0010_0001);
    apb(1'b1, card_if_pkg::CMD_OFS, 32'h0000_1045);
    repeat (120) @(posedge pclk);
    stat(32'h0010_0000, 32'h0);
    pulse(RSTART);
    resp <= '{index: 6'h09, dir_bit: 1'b0, end_bit: 1'b1, crc_recv: 7'h11, crc_calc: 7'h12};
    pulse(RVALID);
    stat(32'h001F_0000, 32'h0007_0000);
    pulse(CSENT);
    apb(1'b1, card_if_pkg::CMD_OFS, 32'h0000_0005);
    stat(32'h001D_0000, 32'h0);
    pulse(CSENT);
    $display("command test done");
  endtask

  task automatic t_data();
    apb(1'b1, card_if_pkg::TXDATA_OFS, 32'h1234_5678);
    @(posedge pclk);
    chk(tx_data, 32'h1234_5678);
    stat(32'h0000_0004, 32'h0);
    pulse(TXL);
    stat(32'h0000_0004, 32'h4);
    pulse(TXL);
    stat(32'h8000_0000, 32'h8000_0000);
    apb(1'b1, card_if_pkg::CMD_OFS, 32'h0001_0005);
    stat(32'hC000_0010, 32'h0000_0010);
    pulse(BEND);
    stat(32'h0000_0008, 32'h8);
    stat(32'h0000_0008, 32'h0);
    pulse(CRCD);
    stat(32'h0000_0010, 32'h0);
    rx_counter_zero <= 1'b1;
    rx_next_counter_zero <= 1'b1;
    repeat (3) @(posedge pclk);
    stat(32'h0000_4040, 32'h0000_4040);
    rx_counter_zero <= 1'b0;
    pulse(RXCW);
    stat(32'h0000_4040, 32'h0);
    $display("data test done");
  endtask

  task automatic t_mode();
    apb(1'b1, card_if_pkg::MODE_OFS, 32'h0000_8000);
    apb(1'b1, card_if_pkg::DTO_OFS, 32'h0000_0012);
    apb(1'b0, card_if_pkg::DTO_OFS, 32'h0);
    chk(q, 32'h0000_0012);
    chk({31'h0, dma_oriented_mode}, 32'h1);
    pulse(RXV);
    pulse(RXV);
    pulse(TXL);
    stat(32'hC000_0000, 32'h0);
    pulse(BEND);
    stat(32'h0000_0008, 32'h0);
    last_block <= 1'b1;
    pulse(BEND);
    stat(32'h0000_0008, 32'h8);
    data_crc <= '{crc_recv: 16'h0001, crc_calc: 16'h0002};
    pulse(DCRC);
    stat(32'h0020_0000, 32'h0020_0000);
    pulse(CSENT);
    apb(1'b1, card_if_pkg::CMD_OFS, 32'h0001_0005);
    @(posedge pclk);
    chk({31'h0, cmd_start}, 32'h1);
    // limit 2 x 16 = 32 cycles, expiry lands between the two reads
    data_wait <= 1'b1;
    repeat (28) @(posedge pclk);
    stat(32'h0060_0010, 32'h0000_0010);
    repeat (4) @(posedge pclk);
    stat(32'h0040_0000, 32'h0040_0000);
    data_wait <= 1'b0;
    tx_counter_zero <= 1'b1;
    tx_next_counter_zero <= 1'b1;
    repeat (3) @(posedge pclk);
    stat(32'h0000_8080, 32'h0000_8080);
    tx_counter_zero <= 1'b0;
    pulse(TXCW);
    stat(32'h0000_8080, 32'h0);
    $display("mode test done");
  endtask

  task automatic t_rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, card_if_pkg::IRQ_MASK_OFS, 32'h0);
    chk(q, 32'h0);
    stat(32'hC07F_C0DF, 32'h0000_0005);
    chk({31'h0, dma_oriented_mode}, 32'h0);
    $display("second reset test done");
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_irq();
    t_cmd();
    t_data();
    t_mode();
    t_rst();
    wrap_up();
  end
endmodule
